// ==== hom_ctrl.sv ====
// Holdover mode control: AXI4-Lite register bank and holdover frequency
// selection for the primary timing PLL.
// Assumes loop status inputs synchronous to aclk; single outstanding access.
// Frequency registers hold raw bytes; the averagers never write them back, so
// reading the average leaves the programmed word untouched.
`timescale 1ns/1ps
module hom_ctrl #(
  parameter int SLOW_TICKS = hom_pkg::SLOW_TICK_CYCLES,
  parameter int FAST_TICKS = hom_pkg::FAST_TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [hom_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [hom_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [hom_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [hom_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [hom_pkg::FREQ_W-1:0] pll_freq,
  input wire logic pll_locked,
  input wire logic pll_holdover,
  input wire logic pll_mini_holdover,
  output logic [hom_pkg::FREQ_W-1:0] holdover_freq,
  output hom_pkg::hom_src_t holdover_src
);
  import hom_pkg::*;

  // Bus phases, one-hot
  typedef enum logic [1:0] {
    WS_ACCEPT = 2'b01,
    WS_RESP = 2'b10
  } hom_wr_t;

  typedef enum logic [1:0] {
    RS_ACCEPT = 2'b01,
    RS_DATA = 2'b10
  } hom_rd_t;

  typedef struct packed {
    hom_wr_t wst;
    hom_rd_t rst;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DW-1:0] rdata;
    logic [1:0] rresp;
    logic [7:0] freq_lo;
    logic [7:0] freq_mid;
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [FREQ_W-1:0] hold_freq;
    hom_src_t src;
  } hom_state_t;

  localparam hom_state_t S_RST = '{
    wst: WS_ACCEPT,
    rst: RS_ACCEPT,
    awready: 1'b0,
    wready: 1'b0,
    aw_got: 1'b0,
    w_got: 1'b0,
    awaddr: '0,
    wbyte: BYTE_RST,
    wlane0: 1'b0,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    arready: 1'b0,
    rvalid: 1'b0,
    rdata: '0,
    rresp: RESP_OKAY,
    freq_lo: BYTE_RST,
    freq_mid: BYTE_RST,
    mode: MODE_RST,
    ctrl: BYTE_RST,
    hold_freq: '0,
    src: SRC_FROZEN
  };

  hom_state_t s_q, s_d;

  logic avg_run;
  logic [FREQ_W-1:0] slow_avg;
  logic [FREQ_W-1:0] fast_avg;
  logic [FREQ_W-1:0] frozen;
  logic [FREQ_W-1:0] manual_word;
  logic [FREQ_W-1:0] avg_sel;
  logic [1:0] mini_code;

  // Averagers run only while locked with the input present. Both rates run
  // side by side, so a rate change made during holdover takes effect at once
  // without waiting for the newly chosen filter to settle.
  assign avg_run = pll_locked && !pll_holdover && !pll_mini_holdover;

  hom_avg #(
    .TICK_CYCLES(SLOW_TICKS)
  ) u_slow (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(avg_run),
    .sample(pll_freq),
    .avg(slow_avg)
  );

  hom_avg #(
    .TICK_CYCLES(FAST_TICKS)
  ) u_fast (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(avg_run),
    .sample(pll_freq),
    .avg(fast_avg)
  );

  // Frozen value trails the loop by one cycle; at holdover entry it keeps the
  // last sample taken while the loop was still locked.
  hom_freeze u_freeze (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(avg_run),
    .sample(pll_freq),
    .frozen(frozen)
  );

  // Programmed word: top bits from the mode register, signed
  assign manual_word = {s_q.mode[FREQ_HI_W-1:0], s_q.freq_mid, s_q.freq_lo};
  // Average chosen by the rate bit
  assign avg_sel = s_q.mode[FAST_BIT] ? fast_avg : slow_avg;
  assign mini_code = s_q.mode[MINI_LSB+1:MINI_LSB];

  // Source for full holdover
  // Forced manual wins over the averaging enable; averaging off means frozen
  function automatic hom_src_t full_src(logic [7:0] mode, logic [7:0] ctrl);
    if (ctrl[FORCE_MAN_BIT]) begin
      full_src = SRC_MANUAL;
    end else if (mode[AVG_EN_BIT]) begin
      full_src = mode[FAST_BIT] ? SRC_FAST : SRC_SLOW;
    end else begin
      full_src = SRC_FROZEN;
    end
  endfunction

  // Source for mini-holdover
  // Codes 10 and 11 take an averager even under forced manual holdover
  function automatic hom_src_t mini_src(logic [1:0] code, hom_src_t full);
    unique case (code)
      MINI_FULL: mini_src = full;
      MINI_FROZEN: mini_src = SRC_FROZEN;
      MINI_FAST: mini_src = SRC_FAST;
      MINI_SLOW: mini_src = SRC_SLOW;
    endcase
  endfunction

  // Frequency value for a source
  function automatic logic [FREQ_W-1:0] src_val(hom_src_t src,
                                                 logic [FREQ_W-1:0] man,
                                                 logic [FREQ_W-1:0] frz,
                                                 logic [FREQ_W-1:0] fst,
                                                 logic [FREQ_W-1:0] slw);
    unique case (src)
      SRC_MANUAL: src_val = man;
      SRC_FROZEN: src_val = frz;
      SRC_FAST: src_val = fst;
      SRC_SLOW: src_val = slw;
    endcase
  endfunction

  // Register read mux, low byte used, upper bits zero
  // Status reads expose the live selection so software can watch holdover
  function automatic logic [AXI_DW-1:0] rd_mux(logic [AXI_AW-1:0] a,
                                               hom_state_t q,
                                               logic [FREQ_W-1:0] avg,
                                               logic run);
    rd_mux = '0;
    if (hom_hit(a, IDX_FREQ_LO)) begin
      rd_mux[7:0] = q.mode[READ_AVG_BIT] ? avg[7:0] : q.freq_lo;
    end else if (hom_hit(a, IDX_FREQ_MID)) begin
      rd_mux[7:0] = q.mode[READ_AVG_BIT] ? avg[15:8] : q.freq_mid;
    end else if (hom_hit(a, IDX_MODE)) begin
      rd_mux[7:0] = q.mode;
    end else if (hom_hit(a, IDX_CTRL)) begin
      rd_mux[7:0] = q.ctrl;
    end else if (hom_hit(a, IDX_STATUS)) begin
      rd_mux[7:0] = {3'h0, run, pll_mini_holdover, pll_holdover, q.src};
    end
  endfunction

  // True for any mapped register
  // Unmapped offsets answer with an error and store nothing
  function automatic logic mapped(logic [AXI_AW-1:0] a);
    mapped = hom_hit(a, IDX_FREQ_LO) || hom_hit(a, IDX_FREQ_MID)
             || hom_hit(a, IDX_MODE) || hom_hit(a, IDX_CTRL)
             || hom_hit(a, IDX_STATUS);
  endfunction

  // Next state: write channel, read channel, holdover selection
  always_comb begin
    s_d = s_q;
    // Write path: address and data in either order
    unique case (s_q.wst)
      WS_ACCEPT: begin
        if (s_axi_awvalid && s_q.awready) begin
          s_d.aw_got = 1'b1;
          s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
          s_d.w_got = 1'b1;
          s_d.wbyte = s_axi_wdata[7:0];
          s_d.wlane0 = s_axi_wstrb[0];
        end
        s_d.awready = !s_d.aw_got;
        s_d.wready = !s_d.w_got;
        if (s_q.aw_got && s_q.w_got) begin
          s_d.bvalid = 1'b1;
          s_d.bresp = mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
          s_d.wst = WS_RESP;
          if (s_q.wlane0) begin
            if (hom_hit(s_q.awaddr, IDX_FREQ_LO)) begin
              s_d.freq_lo = s_q.wbyte;
            end
            if (hom_hit(s_q.awaddr, IDX_FREQ_MID)) begin
              s_d.freq_mid = s_q.wbyte;
            end
            if (hom_hit(s_q.awaddr, IDX_MODE)) begin
              s_d.mode = s_q.wbyte;
            end
            if (hom_hit(s_q.awaddr, IDX_CTRL)) begin
              s_d.ctrl = s_q.wbyte;
            end
          end
        end
      end
      WS_RESP: begin
        if (s_axi_bready) begin
          s_d.bvalid = 1'b0;
          s_d.aw_got = 1'b0;
          s_d.w_got = 1'b0;
          s_d.awready = 1'b1;
          s_d.wready = 1'b1;
          s_d.wst = WS_ACCEPT;
        end
      end
      default: begin
        // Illegal phase code: back to idle, drop any half-taken write
        s_d.wst = WS_ACCEPT;
        s_d.aw_got = 1'b0;
        s_d.w_got = 1'b0;
        s_d.awready = 1'b0;
        s_d.wready = 1'b0;
        s_d.bvalid = 1'b0;
      end
    endcase
    // Read path: data one edge after the address is taken
    unique case (s_q.rst)
      RS_ACCEPT: begin
        s_d.arready = 1'b1;
        if (s_axi_arvalid && s_q.arready) begin
          s_d.arready = 1'b0;
          s_d.rvalid = 1'b1;
          s_d.rdata = rd_mux(s_axi_araddr, s_q, avg_sel, avg_run);
          s_d.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
          s_d.rst = RS_DATA;
        end
      end
      RS_DATA: begin
        if (s_axi_rready) begin
          s_d.rvalid = 1'b0;
          s_d.arready = 1'b1;
          s_d.rst = RS_ACCEPT;
        end
      end
      default: begin
        // Illegal phase code: back to idle with no data pending
        s_d.rst = RS_ACCEPT;
        s_d.arready = 1'b0;
        s_d.rvalid = 1'b0;
      end
    endcase
    // Holdover frequency: mini-holdover has its own choice
    if (pll_mini_holdover) begin
      s_d.src = mini_src(mini_code, full_src(s_q.mode, s_q.ctrl));
    end else begin
      s_d.src = full_src(s_q.mode, s_q.ctrl);
    end
    // Value follows the new source so both outputs change at the same edge
    s_d.hold_freq = src_val(s_d.src, manual_word, frozen, fast_avg, slow_avg);
  end

  // State register, synchronous reset
  // Reset restores every field of the state, mode register included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  // No logic sits between these flops and the pins
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign holdover_freq = s_q.hold_freq;
  assign holdover_src = s_q.src;
endmodule

// ==== hom_pkg.sv ====
// Package for the holdover mode control block: map, fields, timing.
// Assumes a 100 MHz aclk and 32-bit AXI4-Lite with word-aligned access.
package hom_pkg;
  // Bus widths and responses
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register indices; byte address is four times the index
  localparam logic [AXI_AW-1:0] IDX_FREQ_LO = 12'h03E;
  localparam logic [AXI_AW-1:0] IDX_FREQ_MID = 12'h03F;
  localparam logic [AXI_AW-1:0] IDX_MODE = 12'h040;
  localparam logic [AXI_AW-1:0] IDX_CTRL = 12'h041;
  localparam logic [AXI_AW-1:0] IDX_STATUS = 12'h042;
  // Mode and control register fields and reset values
  localparam int AVG_EN_BIT = 7;
  localparam int FAST_BIT = 6;
  localparam int READ_AVG_BIT = 5;
  localparam int MINI_LSB = 3;
  localparam int FREQ_HI_W = 3;
  localparam logic [7:0] MODE_RST = 8'h88;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int FORCE_MAN_BIT = 0;
  localparam int FREQ_W = 19;
  localparam logic [1:0] MINI_FULL = 2'h0;
  localparam logic [1:0] MINI_FROZEN = 2'h1;
  localparam logic [1:0] MINI_FAST = 2'h2;
  localparam logic [1:0] MINI_SLOW = 2'h3;
  // Frequency word LSB in ppm, scaled by 1e7
  localparam int PPM_LSB_E7 = 3068;
  // Averager timing: corner in minutes to update interval in cycles
  localparam longint CLK_HZ = 100_000_000;
  localparam longint SLOW_CORNER_MIN = 110;
  localparam longint FAST_CORNER_MIN = 8;
  localparam int AVG_SHIFT = 16;
  localparam longint TWO_PI_E3 = 6283;
  localparam int SLOW_TICK_CYCLES =
    int'(SLOW_CORNER_MIN * 60 * CLK_HZ * 1000 / (TWO_PI_E3 << AVG_SHIFT));
  localparam int FAST_TICK_CYCLES =
    int'(FAST_CORNER_MIN * 60 * CLK_HZ * 1000 / (TWO_PI_E3 << AVG_SHIFT));
  // Holdover frequency source
  typedef enum logic [1:0] {
    SRC_MANUAL = 2'h0,
    SRC_FROZEN = 2'h1,
    SRC_FAST = 2'h2,
    SRC_SLOW = 2'h3
  } hom_src_t;

  // True when a byte address hits a register index
  function automatic logic hom_hit(logic [AXI_AW-1:0] addr,
                                   logic [AXI_AW-1:0] idx);
    hom_hit = (addr == {idx[AXI_AW-3:0], 2'h0});
  endfunction
endpackage

// ==== hom_freeze.sv ====
// Frozen-frequency capture for holdover entry.
// Assumes run is high only while the loop is locked with its input present.
`timescale 1ns/1ps
module hom_freeze (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [hom_pkg::FREQ_W-1:0] sample,
  output logic [hom_pkg::FREQ_W-1:0] frozen
);
  import hom_pkg::*;
  typedef struct packed {
    logic [FREQ_W-1:0] val;
  } hom_frz_t;
  hom_frz_t s_q, s_d;

  // Track while locked, hold the last value once holdover starts
  always_comb begin
    s_d = s_q;
    if (run) begin
      s_d.val = sample;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign frozen = s_q.val;
endmodule

// ==== hom_avg.sv ====
// First-order averager of the loop frequency for holdover.
// Assumes run drops for holdover and mini-holdover; TICK_CYCLES sets corner.
`timescale 1ns/1ps
module hom_avg #(
  parameter int TICK_CYCLES = 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [hom_pkg::FREQ_W-1:0] sample,
  output logic [hom_pkg::FREQ_W-1:0] avg
);
  import hom_pkg::*;
  localparam int ACC_W = FREQ_W + AVG_SHIFT;
  typedef struct packed {
    logic [23:0] cnt;
    logic primed;
    logic signed [ACC_W-1:0] acc;
  } hom_avg_t;
  hom_avg_t s_q, s_d;
  logic signed [ACC_W:0] diff;

  // Step acc toward the sample by 2^-AVG_SHIFT of the error each tick
  always_comb begin
    s_d = s_q;
    diff = $signed({sample[FREQ_W-1], sample, {AVG_SHIFT{1'b0}}})
           - $signed({s_q.acc[ACC_W-1], s_q.acc});
    if (run) begin
      if (!s_q.primed) begin
        s_d.primed = 1'b1;
        s_d.acc = $signed({sample, {AVG_SHIFT{1'b0}}});
        s_d.cnt = '0;
      end else if (s_q.cnt == 24'(TICK_CYCLES - 1)) begin
        s_d.cnt = '0;
        s_d.acc = s_q.acc + ACC_W'(diff >>> AVG_SHIFT);
      end else begin
        s_d.cnt = s_q.cnt + 24'h000001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign avg = s_q.acc[ACC_W-1:AVG_SHIFT];
endmodule

// ==== hom_ctrl_chk.sv ====
// Checker for hom_ctrl: bus handshakes and frozen holdover value.
// Assumes it is bound to hom_ctrl and sees only its ports.
`timescale 1ns/1ps
module hom_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pll_holdover,
  input wire logic [18:0] holdover_freq,
  input hom_pkg::hom_src_t holdover_src
);
  import hom_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshake and holdover steps
  sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_wr; s_aw ##0 (s_axi_wvalid && s_axi_wready); endsequence
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_hold3; pll_holdover [*3]; endsequence
  chk_aw_refused: assert property (s_aw |=> !s_axi_awready)
    else $error("awready high after address taken");
  chk_ar_refused: assert property (s_ar |=> !s_axi_arready && s_axi_rvalid)
    else $error("read not answered one cycle after address");
  chk_b_after_wr: assert property (s_wr |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after response taken");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held until taken");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released after data taken");
  chk_rdata_hi: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_frozen_hold: assert property (s_hold3 ##0 (holdover_src == SRC_FROZEN && $past(holdover_src) == SRC_FROZEN)
    |-> $stable(holdover_freq))
    else $error("frozen holdover value moved during holdover");
endmodule
bind hom_ctrl hom_chk i_hom_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .pll_holdover, .holdover_freq, .holdover_src);

// ==== dpll_holdover_mode_control_bench.sv ====
// Self-checking bench for hom_ctrl: mode register, selection, readback.
// Assumes short averager ticks; the bench drives every port itself.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module dpll_holdover_mode_control_bench;
  import hom_pkg::*;
  localparam logic [11:0] A_LO = {IDX_FREQ_LO[9:0], 2'h0};
  localparam logic [11:0] A_MID = {IDX_FREQ_MID[9:0], 2'h0};
  localparam logic [11:0] A_MODE = {IDX_MODE[9:0], 2'h0};
  localparam logic [11:0] A_CTRL = {IDX_CTRL[9:0], 2'h0};
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, pll_locked = 1, pll_holdover = 0, pll_mini_holdover = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [18:0] pll_freq = 19'h00ABC, holdover_freq;
  hom_src_t holdover_src;
  int error_cnt = 0, num_checks = 0;
  hom_ctrl #(.SLOW_TICKS(4), .FAST_TICKS(2)) i_hom_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pll_freq, .pll_locked, .pll_holdover, .pll_mini_holdover, .holdover_freq, .holdover_src);
  // Clock source
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_ok(input logic ok);
    if (!ok) begin
      error_cnt++;
      $display("[FAIL] bus wait expired");
      tally_and_finish;
    end
  endtask
  // Write one register; address and data offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    wait_ok(s_axi_bvalid === 1'b1);
    s_axi_bready <= 0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  // Read one register; rready comes a cycle late
  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) && n < 50);
    wait_ok(s_axi_rvalid === 1'b1);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK("rresp", RESP_OKAY, r)
    `CHK("rdata", e, d)
  endtask
  // Selected source and value once the registered output has settled
  task automatic out_chk(input hom_src_t es, input logic [18:0] ef);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    `CHK("src", es, holdover_src)
    `CHK("freq", ef, holdover_freq)
  endtask
  task automatic t_reset;
    rd_chk(A_MODE, 8'h88);
    out_chk(SRC_SLOW, 19'h00ABC);
  endtask
  task automatic t_rate;
    wr(A_MODE, 8'hC8, RESP_OKAY);
    out_chk(SRC_FAST, 19'h00ABC);
  endtask
  task automatic t_manual;
    wr(A_LO, 8'h34, RESP_OKAY);
    wr(A_MID, 8'h12, RESP_OKAY);
    wr(A_MODE, 8'hCD, RESP_OKAY);
    wr(A_CTRL, 8'h01, RESP_OKAY);
    out_chk(SRC_MANUAL, 19'h51234);
    rd_chk(A_LO, 8'h34);
    wr(A_MODE, 8'hED, RESP_OKAY);
    rd_chk(A_LO, 8'hBC);
    rd_chk(A_MID, 8'h0A);
    rd_chk(A_MODE, 8'hED);
  endtask
  task automatic t_mini;
    hom_src_t es [4] = '{SRC_MANUAL, SRC_FROZEN, SRC_FAST, SRC_SLOW};
    @(posedge aclk);
    pll_mini_holdover <= 1;
    for (int c = 0; c < 4; c++) begin
      wr(A_MODE, {3'h4, c[1:0], 3'h5}, RESP_OKAY);
      out_chk(es[c], (c == 0) ? 19'h51234 : 19'h00ABC);
    end
    @(posedge aclk);
    pll_mini_holdover <= 0;
  endtask
  task automatic t_frozen;
    wr(A_CTRL, 8'h00, RESP_OKAY);
    wr(A_MODE, 8'h08, RESP_OKAY);
    out_chk(SRC_FROZEN, 19'h00ABC);
    @(posedge aclk);
    pll_holdover <= 1;
    pll_freq <= 19'h7F0F0;
    repeat (20) @(posedge aclk);
    out_chk(SRC_FROZEN, 19'h00ABC);
    wr(A_MODE, 8'hC8, RESP_OKAY);
    out_chk(SRC_FAST, 19'h00ABC);
  endtask
  task automatic t_bad;
    logic [7:0] d;
    logic [1:0] r;
    wr(12'h200, 8'h55, RESP_SLVERR);
    rd(12'h200, d, r);
    `CHK("rresp", RESP_SLVERR, r)
    `CHK("rdata", 8'h00, d)
    rd_chk(A_MODE, 8'hC8);
  endtask
  // Step the loop frequency while locked; fast averager must move further
  task automatic t_avg;
    logic [7:0] f;
    logic [7:0] s;
    logic [1:0] r;
    @(posedge aclk);
    pll_holdover <= 0;
    pll_freq <= 19'h10ABC;
    repeat (40) @(posedge aclk);
    pll_holdover <= 1;
    wr(A_MODE, 8'hE8, RESP_OKAY);
    rd(A_LO, f, r);
    wr(A_MODE, 8'hA8, RESP_OKAY);
    rd(A_LO, s, r);
    `CHK("fast ahead", 1'b1, f > s)
    `CHK("slow moved", 1'b1, s > 8'hBC)
  endtask
  // Mid-run reset brings the mode register back to its reset pattern
  task automatic t_rst2;
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd_chk(A_MODE, MODE_RST);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_rate;
    t_manual;
    t_mini;
    t_frozen;
    t_bad;
    t_avg;
    t_rst2;
    tally_and_finish;
  end
endmodule
